/* logic/ppp_pkg.sv */
// constants and carrier types for the parallel programming port
// assumes a single 100 MHz core clock and synchronous active-low reset
// What this block does
// - action 01 with high byte select stores bus as high data byte
// - page latch pulse with high select copies data bytes into page buffer
// - low address bits pick word; upper low-byte bits join page address
// - action 00 with high select stores bus as high address byte
// - write strobe low with high select 0 programs page, busy low meanwhile
// - loading command no-operation clears internal write signals
// - eeprom write command loads, latches and programs one eeprom page
// - flash read drives low byte or high byte by high select
// - eeprom read drives addressed byte with output enable low
// - fuse low write uses command, data byte, both selects 0, strobe
// - fuse high write same but high select 1, second select 0
// - fuse data bit 0 programs, bit 1 erases
// - lock write: zero bits program; only reset sets them back to 1
// - fuse/lock read picks low fuse, high fuse or lock by selects
// - signature read drives byte at low address 0 to 2
// - signature command with high select 1 drives calibration byte at low address 0
// - action code: 00 address, 01 data, 10 command, 11 idle
// - command and address are kept across operations
// - data bus is input except while output enable is low
package ppp_pkg;
  localparam int FLASH_AW = 13;
  localparam int FPAGE_W = 6;
  localparam int FPAGE_WORDS = 64;
  localparam int EE_AW = 9;
  localparam int EPAGE_W = 2;
  localparam int EPAGE_BYTES = 4;
  localparam int FLASH_WORDS = 8192;
  localparam int EE_BYTES = 512;

  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;

  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;

  localparam logic [7:0] FUSE_LO_RST = 8'hff;
  localparam logic [7:0] FUSE_HI_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;
  // signature and calibration values are arbitrary
  localparam logic [7:0] SIG0 = 8'h5a;
  localparam logic [7:0] SIG1 = 8'h12;
  localparam logic [7:0] SIG2 = 8'h34;
  localparam logic [7:0] CAL_RST = 8'h80;

  localparam real WR_NS_FLASH = 4500000.0;
  localparam real WR_NS_EE = 9000000.0;
  localparam real WR_NS_FUSE = 4500000.0;
  localparam real CLK_NS = 10.0;
  localparam int WR_CYC_FLASH = int'(WR_NS_FLASH / CLK_NS);
  localparam int WR_CYC_EE = int'(WR_NS_EE / CLK_NS);
  localparam int WR_CYC_FUSE = int'(WR_NS_FUSE / CLK_NS);
  localparam int SYNC_W = 9;

  typedef struct packed {
    logic oe_n;
    logic wr_n;
    logic bs_hi;
    logic bs_2;
    logic xa1;
    logic xa0;
    logic page_latch_strobe;
    logic xtal;
  } ppp_pins_s;

  typedef enum logic [1:0] {PPP_IDLE, PPP_FLASH, PPP_EE, PPP_BYTE} ppp_state_e;
endpackage

/* logic/ppp_port.sv */
// parallel programming port: command/address/data loading, page buffers,
// flash/eeprom/fuse/lock arrays in flip-flops, read mux and busy timer
// assumes pins are asynchronous; write time counts are parameters
module ppp_port #(
  parameter int WR_FLASH_CYC = ppp_pkg::WR_CYC_FLASH, // flash page write
  parameter int WR_EE_CYC = ppp_pkg::WR_CYC_EE, // eeprom page write
  parameter int WR_FUSE_CYC = ppp_pkg::WR_CYC_FUSE // fuse/lock write
) (
  input wire logic core_clk, // core clock
  input wire logic nrst, // sync reset, active low
  input wire ppp_pkg::ppp_pins_s pins, // control pins, raw
  input wire logic [7:0] data_in, // data bus input
  output logic [7:0] data_out, // data bus output, registered
  output logic data_oe_n, // bus enable, low drives
  output logic ready_busy_flag // 1 ready, 0 busy
);
  import ppp_pkg::*;

  typedef struct packed {
    ppp_state_e state;
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] lock;
    logic [22:0] timer;
    logic [FPAGE_W-1:0] widx;
    logic xtal_d;
    logic page_latch_strobe_d;
    logic wr_d;
    logic [7:0] dout;
    logic oe_n;
  } ppp_core_s;

  ppp_core_s st, next_st;
  ppp_pins_s p;
  logic [SYNC_W-1:0] sync_q;
  logic [15:0] fbuf [FPAGE_WORDS];
  logic [FPAGE_WORDS-1:0] fbuf_v;
  logic [7:0] ebuf [EPAGE_BYTES];
  logic [EPAGE_BYTES-1:0] ebuf_v;
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [FLASH_AW-1:0] faddr;
  logic [EE_AW-1:0] eaddr;
  logic xtal_rise, page_latch_strobe_rise, wr_fall;
  logic buf_clr, latch_f, latch_e, commit_f, commit_e;

  ppp_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .raw({pins, 1'b0}),
    .idle_val(9'h180),
    .clean(sync_q)
  );
  assign p = ppp_pins_s'(sync_q[SYNC_W-1:1]);

  assign faddr = {st.addr_hi[FLASH_AW-9:0], st.addr_lo};
  assign eaddr = {st.addr_hi[EE_AW-9:0], st.addr_lo};

  assign xtal_rise = p.xtal && !st.xtal_d;
  assign page_latch_strobe_rise = p.page_latch_strobe && !st.page_latch_strobe_d;
  // wr_d resets high, so a released strobe gives no false edge
  assign wr_fall = !p.wr_n && st.wr_d;

  function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] k);
    return c == k;
  endfunction

  always_comb begin
    // command and address held until reloaded
    next_st = st;
    buf_clr = 1'b0;
    latch_f = 1'b0;
    latch_e = 1'b0;
    commit_f = 1'b0;
    commit_e = 1'b0;
    next_st.xtal_d = p.xtal;
    next_st.page_latch_strobe_d = p.page_latch_strobe;
    next_st.wr_d = p.wr_n;
    if (xtal_rise) begin
      unique case ({p.xa1, p.xa0})
        ACT_ADDR: begin
          if (p.bs_hi) begin
            next_st.addr_hi = data_in;
          end else begin
            next_st.addr_lo = data_in;
          end
        end
        ACT_DATA: begin
          if (p.bs_hi) begin
            next_st.data_hi = data_in;
          end else begin
            next_st.data_lo = data_in;
          end
        end
        ACT_CMD: begin
          next_st.cmd = data_in;
          if (is_cmd(data_in, CMD_NOP)) begin
            buf_clr = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (page_latch_strobe_rise && st.state == PPP_IDLE) begin
      if (is_cmd(st.cmd, CMD_WR_FLASH) && p.bs_hi) begin
        latch_f = 1'b1;
      end
      if (is_cmd(st.cmd, CMD_WR_EE)) begin
        latch_e = 1'b1;
      end
    end
    unique case (st.state)
      PPP_IDLE: begin
        if (wr_fall && !p.bs_hi && is_cmd(st.cmd, CMD_WR_FLASH)) begin
          next_st.state = PPP_FLASH;
          next_st.timer = 23'(WR_FLASH_CYC - 1);
          next_st.widx = '0;
        end else if (wr_fall && !p.bs_hi && is_cmd(st.cmd, CMD_WR_EE)) begin
          next_st.state = PPP_EE;
          next_st.timer = 23'(WR_EE_CYC - 1);
        end else if (wr_fall && is_cmd(st.cmd, CMD_WR_FUSE) && !p.bs_2) begin
          if (p.bs_hi) begin
            next_st.fuse_hi = st.data_lo;
          end else begin
            next_st.fuse_lo = st.data_lo;
          end
          next_st.state = PPP_BYTE;
          next_st.timer = 23'(WR_FUSE_CYC - 1);
        end else if (wr_fall && is_cmd(st.cmd, CMD_WR_LOCK)) begin
          // lock bits only ever clear to zero
          next_st.lock = st.lock & st.data_lo;
          next_st.state = PPP_BYTE;
          next_st.timer = 23'(WR_FUSE_CYC - 1);
        end
      end
      PPP_FLASH, PPP_EE, PPP_BYTE: begin
        if (st.timer == '0) begin
          next_st.state = PPP_IDLE;
          commit_f = (st.state == PPP_FLASH);
          commit_e = (st.state == PPP_EE);
          buf_clr = (st.state != PPP_BYTE);
        end else begin
          next_st.timer = st.timer - 23'd1;
        end
      end
    endcase
    // drive only while output enable low
    next_st.oe_n = p.oe_n;
    next_st.dout = 8'h00;
    if (is_cmd(st.cmd, CMD_RD_FLASH)) begin
      next_st.dout = p.bs_hi ? flash_mem[faddr][15:8] : flash_mem[faddr][7:0];
    end else if (is_cmd(st.cmd, CMD_RD_EE)) begin
      next_st.dout = ee_mem[eaddr];
    end else if (is_cmd(st.cmd, CMD_RD_FUSE)) begin
      unique case ({p.bs_2, p.bs_hi})
        2'b00: next_st.dout = st.fuse_lo;
        2'b11: next_st.dout = st.fuse_hi;
        2'b01: next_st.dout = st.lock;
        default: next_st.dout = 8'hff;
      endcase
    end else if (is_cmd(st.cmd, CMD_RD_SIG)) begin
      if (p.bs_hi) begin
        next_st.dout = (st.addr_lo == 8'h00) ? CAL_RST : 8'hff;
      end else begin
        unique case (st.addr_lo)
          8'h00: next_st.dout = SIG0;
          8'h01: next_st.dout = SIG1;
          8'h02: next_st.dout = SIG2;
          default: next_st.dout = 8'hff;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '{state: PPP_IDLE, fuse_lo: FUSE_LO_RST, fuse_hi: FUSE_HI_RST,
              lock: LOCK_RST, xtal_d: 1'b0, page_latch_strobe_d: 1'b0, wr_d: 1'b1,
              oe_n: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // page buffers and arrays; arrays are not reset, like real cells
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fbuf_v <= '0;
      ebuf_v <= '0;
    end else begin
      // a latch in the same cycle as a clear still lands
      if (buf_clr) begin
        fbuf_v <= '0;
        ebuf_v <= '0;
      end
      if (latch_f) begin
        fbuf[st.addr_lo[FPAGE_W-1:0]] <= {st.data_hi, st.data_lo};
        fbuf_v[st.addr_lo[FPAGE_W-1:0]] <= 1'b1;
      end
      if (latch_e) begin
        ebuf[st.addr_lo[EPAGE_W-1:0]] <= st.data_lo;
        ebuf_v[st.addr_lo[EPAGE_W-1:0]] <= 1'b1;
      end
    end
  end

  // page taken from high byte plus upper low-byte bits
  // one process per array: the page index is not constant, so split writers would clash
  always_ff @(posedge core_clk) begin
    for (int w = 0; w < FPAGE_WORDS; w++) begin
      if (commit_f && fbuf_v[w]) begin
        flash_mem[{faddr[FLASH_AW-1:FPAGE_W], FPAGE_W'(w)}] <= fbuf[w];
      end
    end
  end
  always_ff @(posedge core_clk) begin
    for (int b = 0; b < EPAGE_BYTES; b++) begin
      if (commit_e && ebuf_v[b]) begin
        ee_mem[{eaddr[EE_AW-1:EPAGE_W], EPAGE_W'(b)}] <= ebuf[b];
      end
    end
  end

  assign data_out = st.dout;
  assign data_oe_n = st.oe_n;
  assign ready_busy_flag = (st.state == PPP_IDLE);
endmodule

/* logic/ppp_sync.sv */
// three-stage synchroniser with agreement filter for a bundle of pins
// assumes inputs are asynchronous to core_clk
module ppp_sync (
  input wire logic core_clk, // core clock
  input wire logic nrst, // sync reset, active low
  input wire logic [ppp_pkg::SYNC_W-1:0] raw, // pin levels
  input wire logic [ppp_pkg::SYNC_W-1:0] idle_val, // reset level per pin
  output logic [ppp_pkg::SYNC_W-1:0] clean // filtered levels
);
  import ppp_pkg::*;
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] q;
  } ppp_sync_s;
  ppp_sync_s st, next_st;
  always_comb begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // change counts only when stages two and three agree
    for (int i = 0; i < SYNC_W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      // start from the idle levels so no false edge follows reset
      st <= '{s1: idle_val, s2: idle_val, s3: idle_val, q: idle_val};
    end else begin
      st <= next_st;
    end
  end
  assign clean = st.q;
endmodule

/* testbench/parallel_program_port_test.sv */
// self-checking bench: programmer task sequences against expected bytes
// assumes short write counts of 20 cycles
module parallel_program_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ppp_pkg::*;
  logic core_clk, nrst, data_oe_n, ready_busy_flag;
  ppp_pins_s pins;
  logic [7:0] data_in, data_out, v;
  logic [7:0] sig [3] = '{SIG0, SIG1, SIG2};
  int error_cnt = 0;
  int checks_done = 0;
  bit busy, ok;
  ppp_port #(.WR_FLASH_CYC(20), .WR_EE_CYC(20), .WR_FUSE_CYC(20)) u_ppp_port (
    .core_clk(core_clk), .nrst(nrst), .pins(pins), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .ready_busy_flag(ready_busy_flag));
  ppp_programmer u_ppp_programmer (.core_clk(core_clk), .data_out(data_out),
    .data_oe_n(data_oe_n), .ready_busy_flag(ready_busy_flag), .pins(pins), .data_in(data_in));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    u_ppp_programmer.load(ACT_CMD, 1'b0, c);
  endtask
  task automatic rdchk(input logic hi, input logic b2, input logic [7:0] exp);
    u_ppp_programmer.rd(hi, b2, v);
    check(v, exp);
  endtask
  // a write that should run but never finishes ends the run
  task automatic wr(input logic hi, input logic b2, input bit exp_busy);
    u_ppp_programmer.prog(hi, b2, busy, ok);
    check({7'h00, busy}, {7'h00, exp_busy});
    if (exp_busy && !ok) begin
      check(8'h00, 8'h01);
      final_report();
    end
  endtask
  initial begin
    nrst = 1'b0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    repeat (6) @(negedge core_clk);
    check({6'h00, ready_busy_flag, data_oe_n}, 8'h03);
    cmd(CMD_RD_FUSE);
    rdchk(1'b0, 1'b0, FUSE_LO_RST);
    rdchk(1'b1, 1'b1, FUSE_HI_RST);
    rdchk(1'b1, 1'b0, LOCK_RST);
    $display("test fuse read done");
    cmd(CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      u_ppp_programmer.load(ACT_ADDR, 1'b0, 8'(i));
      rdchk(1'b0, 1'b0, sig[i]);
    end
    u_ppp_programmer.load(ACT_ADDR, 1'b0, 8'h00);
    rdchk(1'b1, 1'b0, CAL_RST);
    $display("test signature done");
    cmd(CMD_WR_FLASH);
    u_ppp_programmer.load(ACT_ADDR, 1'b1, 8'h01);
    for (int i = 0; i < 2; i++) begin
      u_ppp_programmer.load(ACT_ADDR, 1'b0, 8'h41 + 8'(i));
      u_ppp_programmer.load(ACT_DATA, 1'b0, 8'h34 + 8'(i));
      u_ppp_programmer.load(ACT_DATA, 1'b1, 8'h12 + 8'(i));
      u_ppp_programmer.latch();
    end
    wr(1'b1, 1'b0, 1'b0);
    wr(1'b0, 1'b0, 1'b1);
    cmd(CMD_NOP);
    wr(1'b0, 1'b0, 1'b0);
    cmd(CMD_RD_FLASH);
    u_ppp_programmer.load(ACT_ADDR, 1'b1, 8'h01);
    for (int i = 0; i < 2; i++) begin
      u_ppp_programmer.load(ACT_ADDR, 1'b0, 8'h41 + 8'(i));
      rdchk(1'b0, 1'b0, 8'h34 + 8'(i));
      rdchk(1'b1, 1'b0, 8'h12 + 8'(i));
    end
    u_ppp_programmer.load(2'h3, 1'b0, 8'h41);
    rdchk(1'b0, 1'b0, 8'h35);
    cmd(CMD_WR_FLASH);
    u_ppp_programmer.load(ACT_ADDR, 1'b0, 8'h41);
    u_ppp_programmer.load(ACT_DATA, 1'b0, 8'h55);
    u_ppp_programmer.latch();
    cmd(CMD_NOP);
    cmd(CMD_WR_FLASH);
    wr(1'b0, 1'b0, 1'b1);
    cmd(CMD_RD_FLASH);
    rdchk(1'b0, 1'b0, 8'h34);
    $display("test flash done");
    cmd(CMD_WR_EE);
    u_ppp_programmer.load(ACT_ADDR, 1'b1, 8'h00);
    u_ppp_programmer.load(ACT_ADDR, 1'b0, 8'h05);
    u_ppp_programmer.load(ACT_DATA, 1'b0, 8'h5c);
    u_ppp_programmer.latch();
    wr(1'b0, 1'b0, 1'b1);
    cmd(CMD_RD_EE);
    rdchk(1'b0, 1'b0, 8'h5c);
    $display("test eeprom done");
    cmd(CMD_WR_FUSE);
    u_ppp_programmer.load(ACT_DATA, 1'b0, 8'ha5);
    wr(1'b0, 1'b1, 1'b0);
    wr(1'b0, 1'b0, 1'b1);
    u_ppp_programmer.load(ACT_DATA, 1'b0, 8'h3c);
    wr(1'b1, 1'b0, 1'b1);
    cmd(CMD_WR_LOCK);
    u_ppp_programmer.load(ACT_DATA, 1'b0, 8'hf0);
    wr(1'b0, 1'b0, 1'b1);
    u_ppp_programmer.load(ACT_DATA, 1'b0, 8'h0f);
    wr(1'b0, 1'b0, 1'b1);
    cmd(CMD_RD_FUSE);
    rdchk(1'b0, 1'b0, 8'ha5);
    rdchk(1'b1, 1'b1, 8'h3c);
    rdchk(1'b1, 1'b0, 8'h00);
    $display("test fuse and lock done");
    final_report();
  end
endmodule

/* testbench/ppp_port_monitor.sv */
// assertions on the programming port pins, ready flag and bus enable
// assumes the busy counts are small (tens of cycles) as in simulation
module ppp_port_monitor #(
  parameter int WR_FLASH_CYC = 20, // flash page write
  parameter int WR_EE_CYC = 20, // eeprom page write
  parameter int WR_FUSE_CYC = 20 // fuse/lock write
) (
  input wire logic core_clk, // core clock
  input wire logic nrst, // sync reset, active low
  input wire ppp_pkg::ppp_pins_s pins, // control pins
  input wire logic [7:0] data_in, // bus level
  input wire logic [7:0] data_out, // read byte
  input wire logic data_oe_n, // bus enable, low drives
  input wire logic ready_busy_flag // 1 ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import ppp_pkg::*;
  // the sum bounds every single write time without picking a maximum
  localparam int BUSY_MAX = WR_FLASH_CYC + WR_EE_CYC + WR_FUSE_CYC + 16;
  logic [4:0] wr_age;
  int busy_cnt;
  // real write times are far beyond a delay range, so busy time is counted
  always_ff @(posedge core_clk) begin
    if (!nrst || ready_busy_flag) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) wr_age <= 5'h1f;
    else if (!pins.wr_n) wr_age <= 5'h00;
    else if (wr_age != 5'h1f) wr_age <= wr_age + 5'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence busy_start;
    $fell(ready_busy_flag);
  endsequence
  sequence busy_hold;
    (!ready_busy_flag)[*8];
  endsequence
  a_reset_idle: assert property ($rose(nrst) |-> ready_busy_flag && data_oe_n && data_out == 8'h00)
    else $error("outputs not idle after reset");
  a_ready_after_rst: assert property ($rose(nrst) |-> ready_busy_flag[*4])
    else $error("busy right after reset");
  a_oe_drive: assert property ((nrst && !pins.oe_n)[*8] |-> !data_oe_n)
    else $error("bus not driven while output enable low");
  a_oe_release: assert property ((nrst && pins.oe_n)[*8] |-> data_oe_n)
    else $error("bus driven while output enable high");
  a_busy_cause: assert property (busy_start |-> wr_age < 5'd12)
    else $error("busy without write strobe");
  a_busy_min: assert property (busy_start |=> busy_hold)
    else $error("busy too short");
  a_busy_max: assert property (!ready_busy_flag |-> busy_cnt < BUSY_MAX)
    else $error("busy never ends");
  a_ready_rise_past: assert property ($rose(ready_busy_flag) |-> !$past(ready_busy_flag, 8))
    else $error("ready rose after short busy");
endmodule
bind ppp_port ppp_port_monitor #(.WR_FLASH_CYC(WR_FLASH_CYC), .WR_EE_CYC(WR_EE_CYC),
  .WR_FUSE_CYC(WR_FUSE_CYC)) u_ppp_port_monitor (.core_clk(core_clk), .nrst(nrst),
  .pins(pins), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
  .ready_busy_flag(ready_busy_flag));

/* testbench/ppp_programmer.sv */
// external programmer model: strobes, selects and the shared data bus
// assumes its tasks are called after a falling edge of core_clk
module ppp_programmer (
  input wire logic core_clk, // core clock
  input wire logic [7:0] data_out, // device read byte
  input wire logic data_oe_n, // device bus enable
  input wire logic ready_busy_flag, // device ready
  output ppp_pkg::ppp_pins_s pins, // control pins
  output logic [7:0] data_in // resolved bus level
);
  timeunit 1ns;
  timeprecision 1ps;
  import ppp_pkg::*;
  logic [7:0] drv;
  // device drives only with enable low; floating bus shows inverse
  assign data_in = !data_oe_n ? data_out : (pins.oe_n ? drv : ~drv);
  initial begin
    pins = '{oe_n: 1'b1, wr_n: 1'b1, default: 1'b0};
    drv = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // action code on load strobe, write and latch idle
  task automatic load(input logic [1:0] act, input logic hi, input logic [7:0] d);
    {pins.xa1, pins.xa0} = act;
    pins.bs_hi = hi;
    drv = d;
    hold(8);
    pins.xtal = 1'b1;
    hold(8);
    pins.xtal = 1'b0;
    hold(8);
  endtask
  task automatic latch();
    pins.bs_hi = 1'b1;
    hold(8);
    pins.page_latch_strobe = 1'b1;
    hold(8);
    pins.page_latch_strobe = 1'b0;
    hold(8);
  endtask
  // write pulse, bounded wait for ready, selects back to 0
  task automatic prog(input logic hi, input logic b2, output bit busy, output bit ok);
    busy = 1'b0;
    ok = 1'b0;
    pins.bs_hi = hi;
    pins.bs_2 = b2;
    hold(8);
    pins.wr_n = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      hold(1);
      if (i == 8) pins.wr_n = 1'b1;
      if (ready_busy_flag === 1'b0) busy = 1'b1;
      ok = busy && ready_busy_flag === 1'b1;
    end
    pins.wr_n = 1'b1;
    pins.bs_hi = 1'b0;
    pins.bs_2 = 1'b0;
    hold(8);
  endtask
  task automatic rd(input logic hi, input logic b2, output logic [7:0] v);
    pins.bs_hi = hi;
    pins.bs_2 = b2;
    hold(2);
    pins.oe_n = 1'b0;
    hold(12);
    v = data_in;
    pins.oe_n = 1'b1;
    hold(8);
  endtask
endmodule
